// ==== core/iof_pkg.sv ====
package iof_pkg;
  // opcodes handled by this block
  localparam logic [7:0] OP_INV_F1 = 8'hB5;
  localparam logic [7:0] OP_ZERO_C = 8'h97;
  localparam logic [7:0] OP_ZERO_F0 = 8'h85;
  localparam logic [7:0] OP_ZERO_F1 = 8'hA5;
  localparam logic [7:0] OP_BUS_AND = 8'h98;
  localparam logic [7:0] OP_BUS_OR = 8'h88;
  localparam logic [7:0] OP_BUS_CAP = 8'h08;
  localparam logic [7:0] OP_BUS_OUT = 8'h02;
  // six-bit patterns, low two bits select port
  localparam logic [5:0] PAT_PORT_AND = 6'h26;
  localparam logic [5:0] PAT_PORT_OR = 6'h22;
  localparam logic [5:0] PAT_EXP_AND = 6'h27;
  localparam logic [5:0] PAT_EXP_OR = 6'h23;
  localparam logic [5:0] PAT_PORT_IN = 6'h02;
  localparam logic [5:0] PAT_EXP_RD = 6'h03;
  localparam logic [5:0] PAT_EXP_WR = 6'h0F;
  localparam logic [5:0] PAT_PORT_OUT = 6'h0E;
  // five-bit register patterns, seven-bit indirect pattern
  localparam logic [4:0] PAT_REG_DEC = 5'h19;
  localparam logic [4:0] PAT_REG_INC = 5'h03;
  localparam logic [6:0] PAT_IND_INC = 7'h08;
  // port select codes for ports 1 and 2
  localparam logic [1:0] SEL_P1 = 2'h1;
  localparam logic [1:0] SEL_P2 = 2'h2;
  // memory geometry and reset values
  localparam int RAM_AW = 6;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  typedef enum logic [2:0] {
    IOF_IDLE, IOF_IMM, IOF_EXEC, IOF_STROBE, IOF_RAMRD
  } iof_state_t;
endpackage

// ==== core/iof_ram.sv ====
`timescale 1ns/10ps
`default_nettype none
// internal data memory, registered read data
module iof_ram
  import iof_pkg::*;
(
  input wire logic clock,
  input wire logic [RAM_AW-1:0] rd_addr,
  input wire logic [RAM_AW-1:0] wr_addr,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:(1<<RAM_AW)-1];
  // synchronous write and registered read
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ==== core/iof_exec.sv ====
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - opcode B5 inverts user flag one in one cycle
// - 97 clears carry, 85 clears flag zero, A5 clears flag one
// - 98 ANDs bus with immediate byte, drives result, two cycles
// - 88 ORs bus with immediate byte, drives result, two cycles
// - port AND immediate on port 1 or 2, outputs result, two cycles
// - port OR immediate on port 1 or 2, outputs result, two cycles
// - expander AND/OR with accumulator low nibble, outputs result, two cycles
// - port input loads whole accumulator from port 1 or 2
// - opcode 08 captures bus into accumulator at read strobe rise
// - expander read loads low nibble, clears high nibble
// - expander write sends low nibble, high nibble unchanged
// - opcode 02 latches accumulator on bus at write strobe rise
// - port output latches full accumulator into port 1 or 2
// - register decrement subtracts one from working register 0-7
// - register increment adds one to working register 0-7
// - indirect increment adds one to RAM at register 0/1 bits 0-5
// - low two opcode bits select port
// - low three bits pick register; bit 0 picks indirect register
module iof_exec
  import iof_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  output logic op_ready,
  output logic exec_done,
  input wire logic [7:0] acc_in,
  output logic acc_we,
  output logic [7:0] acc_out,
  output logic carry_clr,
  output logic user_flag_zero,
  output logic user_flag_one,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic bus_oe,
  output logic rd_n,
  output logic wr_n,
  input wire logic [7:0] port1_in,
  input wire logic [7:0] port2_in,
  output logic [7:0] port1_out,
  output logic [7:0] port2_out,
  input wire logic [3:0] exp_in,
  output logic [3:0] exp_out,
  output logic [1:0] exp_sel,
  output logic exp_we
);
  // two-flop synchronisers for pin inputs
  logic [7:0] bus_s1_ff, bus_s2_ff, p1_s1_ff, p1_s2_ff, p2_s1_ff, p2_s2_ff;
  logic [3:0] exp_s1_ff, exp_s2_ff;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus_s1_ff <= RST_BYTE;
      bus_s2_ff <= RST_BYTE;
      p1_s1_ff <= RST_BYTE;
      p1_s2_ff <= RST_BYTE;
      p2_s1_ff <= RST_BYTE;
      p2_s2_ff <= RST_BYTE;
      exp_s1_ff <= RST_NIB;
      exp_s2_ff <= RST_NIB;
    end else begin
      bus_s1_ff <= bus_in;
      bus_s2_ff <= bus_s1_ff;
      p1_s1_ff <= port1_in;
      p1_s2_ff <= p1_s1_ff;
      p2_s1_ff <= port2_in;
      p2_s2_ff <= p2_s1_ff;
      exp_s1_ff <= exp_in;
      exp_s2_ff <= exp_s1_ff;
    end
  end

  // state and working storage
  iof_state_t state_ff, nxt_state;
  logic [7:0] op_ff, nxt_op;
  logic [7:0] imm_ff, nxt_imm;
  logic [7:0] regs_ff [0:7];
  logic [7:0] nxt_regs [0:7];
  logic f0_ff, nxt_f0, f1_ff, nxt_f1;
  logic [7:0] bus_ff, nxt_bus;
  logic bus_oe_ff, nxt_bus_oe;
  logic rd_n_ff, nxt_rd_n, wr_n_ff, nxt_wr_n;
  logic [7:0] p1_ff, nxt_p1, p2_ff, nxt_p2;
  logic [3:0] exp_ff, nxt_exp;
  logic [1:0] exp_sel_ff, nxt_exp_sel;
  logic exp_we_ff, nxt_exp_we;
  logic [7:0] acc_ff, nxt_acc;
  logic acc_we_ff, nxt_acc_we;
  logic carry_clr_ff, nxt_carry_clr;
  logic done_ff, nxt_done;
  logic ram_we;
  logic [RAM_AW-1:0] ram_addr;
  logic [7:0] ram_rd;

  iof_ram u_ram (
    .clock(clock),
    .rd_addr(ram_addr),
    .wr_addr(ram_addr),
    .wr_en(ram_we),
    .wr_data(ram_rd + ONE_BYTE),
    .rd_data(ram_rd)
  );

  // pointer for indirect access: register 0 or 1, bits 0-5
  // the read starts at the edge that takes the opcode, so the registered
  // read data is valid in the write-back cycle and never stale
  logic ram_ptr_sel;
  assign ram_ptr_sel = (state_ff == IOF_IDLE) ? op_byte[0] : op_ff[0];
  assign ram_addr = regs_ff[{2'h0, ram_ptr_sel}][RAM_AW-1:0];
  assign op_ready = (state_ff == IOF_IDLE) || (state_ff == IOF_IMM);

  // decode and execute
  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_imm = imm_ff;
    for (int i = 0; i < 8; i++) begin
      nxt_regs[i] = regs_ff[i];
    end
    nxt_f0 = f0_ff;
    nxt_f1 = f1_ff;
    nxt_bus = bus_ff;
    nxt_bus_oe = bus_oe_ff;
    nxt_rd_n = 1'b1;
    nxt_wr_n = 1'b1;
    nxt_p1 = p1_ff;
    nxt_p2 = p2_ff;
    nxt_exp = exp_ff;
    nxt_exp_sel = exp_sel_ff;
    nxt_exp_we = 1'b0;
    nxt_acc = acc_ff;
    nxt_acc_we = 1'b0;
    nxt_carry_clr = 1'b0;
    nxt_done = 1'b0;
    ram_we = 1'b0;
    unique case (state_ff)
      IOF_IDLE: begin
        if (op_valid) begin
          nxt_op = op_byte;
          nxt_done = 1'b1;
          if (op_byte == OP_INV_F1) begin
            nxt_f1 = ~f1_ff;
          end else if (op_byte == OP_ZERO_C) begin
            nxt_carry_clr = 1'b1;
          end else if (op_byte == OP_ZERO_F0) begin
            nxt_f0 = 1'b0;
          end else if (op_byte == OP_ZERO_F1) begin
            nxt_f1 = 1'b0;
          end else if (op_byte[7:3] == PAT_REG_DEC) begin
            nxt_regs[op_byte[2:0]] = regs_ff[op_byte[2:0]] - ONE_BYTE;
          end else if (op_byte[7:3] == PAT_REG_INC) begin
            nxt_regs[op_byte[2:0]] = regs_ff[op_byte[2:0]] + ONE_BYTE;
          end else if (op_byte[7:1] == PAT_IND_INC) begin
            nxt_done = 1'b0;
            nxt_state = IOF_RAMRD;
          end else if (op_byte == OP_BUS_AND || op_byte == OP_BUS_OR ||
                       (op_byte[7:2] == PAT_PORT_AND && op_byte[1:0] != 2'h0) ||
                       (op_byte[7:2] == PAT_PORT_OR && op_byte[1:0] != 2'h0)) begin
            nxt_done = 1'b0;
            nxt_state = IOF_IMM;
          end else if (op_byte == OP_BUS_CAP) begin
            nxt_done = 1'b0;
            nxt_rd_n = 1'b0;
            nxt_bus_oe = 1'b0;
            nxt_state = IOF_STROBE;
          end else if (op_byte == OP_BUS_OUT) begin
            nxt_done = 1'b0;
            nxt_bus = acc_in;
            nxt_bus_oe = 1'b1;
            nxt_wr_n = 1'b0;
            nxt_state = IOF_STROBE;
          end else begin
            nxt_done = 1'b0;
            nxt_state = IOF_EXEC;
          end
        end
      end
      IOF_IMM: begin
        if (op_valid) begin
          nxt_imm = op_byte;
          nxt_state = IOF_EXEC;
        end
      end
      IOF_RAMRD: begin
        ram_we = 1'b1;
        nxt_done = 1'b1;
        nxt_state = IOF_IDLE;
      end
      IOF_STROBE: begin
        // strobe rises here; capture on the rising edge
        if (op_ff == OP_BUS_CAP) begin
          nxt_acc = bus_s2_ff;
          nxt_acc_we = 1'b1;
        end
        nxt_done = 1'b1;
        nxt_state = IOF_IDLE;
      end
      IOF_EXEC: begin
        nxt_done = 1'b1;
        nxt_state = IOF_IDLE;
        if (op_ff == OP_BUS_AND) begin
          nxt_bus = bus_s2_ff & imm_ff;
          nxt_bus_oe = 1'b1;
        end else if (op_ff == OP_BUS_OR) begin
          nxt_bus = bus_s2_ff | imm_ff;
          nxt_bus_oe = 1'b1;
        end else if (op_ff[7:2] == PAT_PORT_AND) begin
          if (op_ff[1:0] == SEL_P1) nxt_p1 = p1_ff & imm_ff;
          if (op_ff[1:0] == SEL_P2) nxt_p2 = p2_ff & imm_ff;
        end else if (op_ff[7:2] == PAT_PORT_OR) begin
          if (op_ff[1:0] == SEL_P1) nxt_p1 = p1_ff | imm_ff;
          if (op_ff[1:0] == SEL_P2) nxt_p2 = p2_ff | imm_ff;
        end else if (op_ff[7:2] == PAT_EXP_AND) begin
          nxt_exp = exp_s2_ff & acc_in[3:0];
          nxt_exp_sel = op_ff[1:0];
          nxt_exp_we = 1'b1;
        end else if (op_ff[7:2] == PAT_EXP_OR) begin
          nxt_exp = exp_s2_ff | acc_in[3:0];
          nxt_exp_sel = op_ff[1:0];
          nxt_exp_we = 1'b1;
        end else if (op_ff[7:2] == PAT_PORT_IN && op_ff[1:0] != 2'h0) begin
          nxt_acc = (op_ff[1:0] == SEL_P1) ? p1_s2_ff : p2_s2_ff;
          nxt_acc_we = (op_ff[1:0] == SEL_P1) || (op_ff[1:0] == SEL_P2);
        end else if (op_ff[7:2] == PAT_EXP_RD) begin
          nxt_acc = {RST_NIB, exp_s2_ff};
          nxt_acc_we = 1'b1;
          nxt_exp_sel = op_ff[1:0];
        end else if (op_ff[7:2] == PAT_EXP_WR) begin
          nxt_exp = acc_in[3:0];
          nxt_exp_sel = op_ff[1:0];
          nxt_exp_we = 1'b1;
        end else if (op_ff[7:2] == PAT_PORT_OUT) begin
          if (op_ff[1:0] == SEL_P1) nxt_p1 = acc_in;
          if (op_ff[1:0] == SEL_P2) nxt_p2 = acc_in;
        end else begin
          nxt_done = 1'b0; // not ours: no action
        end
      end
      default: begin
        nxt_state = IOF_IDLE;
      end
    endcase
  end

  // register all state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= IOF_IDLE;
      op_ff <= RST_BYTE;
      imm_ff <= RST_BYTE;
      for (int i = 0; i < 8; i++) begin
        regs_ff[i] <= RST_BYTE;
      end
      f0_ff <= 1'b0;
      f1_ff <= 1'b0;
      bus_ff <= RST_BYTE;
      bus_oe_ff <= 1'b0;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      p1_ff <= RST_BYTE;
      p2_ff <= RST_BYTE;
      exp_ff <= RST_NIB;
      exp_sel_ff <= 2'h0;
      exp_we_ff <= 1'b0;
      acc_ff <= RST_BYTE;
      acc_we_ff <= 1'b0;
      carry_clr_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      imm_ff <= nxt_imm;
      for (int i = 0; i < 8; i++) begin
        regs_ff[i] <= nxt_regs[i];
      end
      f0_ff <= nxt_f0;
      f1_ff <= nxt_f1;
      bus_ff <= nxt_bus;
      bus_oe_ff <= nxt_bus_oe;
      rd_n_ff <= nxt_rd_n;
      wr_n_ff <= nxt_wr_n;
      p1_ff <= nxt_p1;
      p2_ff <= nxt_p2;
      exp_ff <= nxt_exp;
      exp_sel_ff <= nxt_exp_sel;
      exp_we_ff <= nxt_exp_we;
      acc_ff <= nxt_acc;
      acc_we_ff <= nxt_acc_we;
      carry_clr_ff <= nxt_carry_clr;
      done_ff <= nxt_done;
    end
  end

  // outputs
  assign exec_done = done_ff;
  assign acc_we = acc_we_ff;
  assign acc_out = acc_ff;
  assign carry_clr = carry_clr_ff;
  assign user_flag_zero = f0_ff;
  assign user_flag_one = f1_ff;
  assign bus_out = bus_ff;
  assign bus_oe = bus_oe_ff;
  assign rd_n = rd_n_ff;
  assign wr_n = wr_n_ff;
  assign port1_out = p1_ff;
  assign port2_out = p2_ff;
  assign exp_out = exp_ff;
  assign exp_sel = exp_sel_ff;
  assign exp_we = exp_we_ff;

  // checks
  sequence s_cap_issue;
    state_ff == IOF_IDLE && op_valid && op_byte == OP_BUS_CAP;
  endsequence
  sequence s_wr_issue;
    state_ff == IOF_IDLE && op_valid && op_byte == OP_BUS_OUT;
  endsequence
  flag_invert_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_ff == IOF_IDLE && op_valid && op_byte == OP_INV_F1)
    |=> (user_flag_one != $past(user_flag_one) && exec_done))
    else $error("flag one not inverted");
  flag_zero_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_ff == IOF_IDLE && op_valid && op_byte == OP_ZERO_F0) |=> !user_flag_zero)
    else $error("flag zero not cleared");
  carry_zero_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_ff == IOF_IDLE && op_valid && op_byte == OP_ZERO_C) |=> carry_clr)
    else $error("carry clear missing");
  bus_capture_a: assert property (@(posedge clock) disable iff (!resetn)
    s_cap_issue |=> !rd_n ##1 (rd_n && acc_we && acc_out == $past(bus_s2_ff)))
    else $error("bus capture wrong");
  bus_latch_a: assert property (@(posedge clock) disable iff (!resetn)
    s_wr_issue |=> (!wr_n && bus_oe && bus_out == $past(acc_in)) ##1 wr_n)
    else $error("bus latch wrong");
  reg_step_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_ff == IOF_IDLE && op_valid && op_byte[7:3] == PAT_REG_INC)
    |=> regs_ff[$past(op_byte[2:0])] == $past(regs_ff[op_byte[2:0]]) + ONE_BYTE)
    else $error("register increment wrong");
  port_out_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_ff == IOF_EXEC && op_ff == {PAT_PORT_OUT, SEL_P1}) |=> port1_out == $past(acc_in))
    else $error("port output wrong");
  exp_read_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_ff == IOF_EXEC && op_ff[7:2] == PAT_EXP_RD) |=> (acc_we && acc_out[7:4] == RST_NIB))
    else $error("expander read high nibble");
  imm_two_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_ff == IOF_IMM && op_valid && op_ff == OP_BUS_AND)
    |=> !exec_done ##1 (exec_done && bus_oe && bus_out == ($past(bus_s2_ff) & $past(imm_ff))))
    else $error("bus and sequence wrong");
  reg_down_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_ff == IOF_IDLE && op_valid && op_byte[7:3] == PAT_REG_DEC)
    |=> regs_ff[$past(op_byte[2:0])] == $past(regs_ff[op_byte[2:0]]) - ONE_BYTE)
    else $error("register decrement wrong");
  ind_step_a: assert property (@(posedge clock) disable iff (!resetn)
    (state_ff == IOF_IDLE && op_valid && op_byte[7:1] == PAT_IND_INC)
    |=> (ram_we && !exec_done && ram_addr == $past(regs_ff[{2'h0, op_byte[0]}][RAM_AW-1:0]))
    ##1 exec_done)
    else $error("indirect increment wrong");
endmodule
`default_nettype wire

// ==== tb/iof_periph.sv ====
`timescale 1ns/10ps
`default_nettype none
// peripherals on the bus and ports: bus latch, quasi ports, nibble expander
module iof_periph
  import iof_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] rd_byte,
  input wire logic [7:0] p1_pull,
  input wire logic [7:0] p2_pull,
  input wire logic [7:0] bus_out,
  input wire logic bus_oe,
  input wire logic wr_n,
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port2_out,
  input wire logic [3:0] exp_out,
  input wire logic [1:0] exp_sel,
  input wire logic exp_we,
  output logic [7:0] bus_in,
  output logic [7:0] port1_in,
  output logic [7:0] port2_in,
  output logic [3:0] exp_in,
  output logic [7:0] wr_seen,
  output logic [15:0] exp_nibs
);
  logic [3:0] nib_ff [4];
  // source keeps its byte on the bus while the device is not driving
  assign bus_in = bus_oe ? bus_out : rd_byte;
  // ports are pulled low by outside loads where the pull mask is 0
  assign port1_in = port1_out & p1_pull;
  assign port2_in = port2_out & p2_pull;
  assign exp_in = nib_ff[exp_sel];
  assign exp_nibs = {nib_ff[3], nib_ff[2], nib_ff[1], nib_ff[0]};
  // write strobe rising edge latches the bus
  always_ff @(posedge wr_n or negedge resetn) begin
    if (!resetn) wr_seen <= 8'h00;
    else wr_seen <= bus_in;
  end
  // expander stores a nibble per port on its write pulse
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) nib_ff <= '{4'h0, 4'h0, 4'h0, 4'h0};
    else if (exp_we) nib_ff[exp_sel] <= exp_out;
  end
endmodule
`default_nettype wire

// ==== tb/io_flag_register_instr_exec_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module io_flag_register_instr_exec_tb;
  import iof_pkg::*;
  logic clock, resetn, op_valid, op_ready, exec_done, acc_we, carry_clr;
  logic user_flag_zero, user_flag_one, bus_oe, rd_n, wr_n, exp_we;
  logic [7:0] op_byte, acc_in, acc_out, bus_in, bus_out, port1_in, port2_in;
  logic [7:0] port1_out, port2_out, rd_byte, p1_pull, p2_pull, wr_seen;
  logic [3:0] exp_in, exp_out;
  logic [1:0] exp_sel;
  logic [15:0] exp_nibs;
  logic got_we, got_carry;
  logic [7:0] got_acc;
  int bad_count = 0, n_compared = 0, cycles = 0, rd_lows, wr_lows;

  iof_exec DUT (.clock(clock), .resetn(resetn), .op_valid(op_valid), .op_byte(op_byte),
    .op_ready(op_ready), .exec_done(exec_done), .acc_in(acc_in), .acc_we(acc_we),
    .acc_out(acc_out), .carry_clr(carry_clr), .user_flag_zero(user_flag_zero),
    .user_flag_one(user_flag_one), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .rd_n(rd_n), .wr_n(wr_n), .port1_in(port1_in), .port2_in(port2_in),
    .port1_out(port1_out), .port2_out(port2_out), .exp_in(exp_in), .exp_out(exp_out),
    .exp_sel(exp_sel), .exp_we(exp_we));
  iof_periph peer (.clock(clock), .resetn(resetn), .rd_byte(rd_byte), .p1_pull(p1_pull),
    .p2_pull(p2_pull), .bus_out(bus_out), .bus_oe(bus_oe), .wr_n(wr_n),
    .port1_out(port1_out), .port2_out(port2_out), .exp_out(exp_out), .exp_sel(exp_sel),
    .exp_we(exp_we), .bus_in(bus_in), .port1_in(port1_in), .port2_in(port2_in),
    .exp_in(exp_in), .wr_seen(wr_seen), .exp_nibs(exp_nibs));

  // clock at 40 ns period
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    n_compared++;
    if (seen !== expd) begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic complete_run;
    $display("mismatches %0d of %0d compares", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // issue one instruction, count cycles to done, note strobes and pulses
  task automatic run(input logic [7:0] op, input bit two, input logic [7:0] imm, input int ek);
    int k;
    k = 0;
    rd_lows = 0;
    wr_lows = 0;
    got_we = 1'b0;
    got_carry = 1'b0;
    @(posedge clock);
    op_valid <= 1'b1;
    op_byte <= op;
    @(posedge clock);
    if (two) begin
      op_byte <= imm;
      @(posedge clock);
    end
    op_valid <= 1'b0;
    // first look just after the edge that took the last byte, then once a cycle
    for (int i = 1; i <= 6 && k == 0; i++) begin
      #1;
      rd_lows += int'(rd_n === 1'b0);
      wr_lows += int'(wr_n === 1'b0);
      if (exec_done === 1'b1) begin
        k = i;
        got_we = acc_we;
        got_acc = acc_out;
        got_carry = carry_clr;
      end else begin
        @(posedge clock);
      end
    end
    check(16'(k), 16'(ek));
    repeat (3) @(posedge clock);
  endtask

  task automatic test_flags;
    run(OP_INV_F1, 0, 8'h00, 1);
    check(16'(user_flag_one), 16'h1);
    run(OP_INV_F1, 0, 8'h00, 1);
    check(16'(user_flag_one), 16'h0);
    run(OP_INV_F1, 0, 8'h00, 1);
    run(OP_ZERO_F1, 0, 8'h00, 1);
    check(16'(user_flag_one), 16'h0);
    run(OP_ZERO_F0, 0, 8'h00, 1);
    check(16'(user_flag_zero), 16'h0);
    run(OP_ZERO_C, 0, 8'h00, 1);
    check(16'(got_carry), 16'h1);
  endtask

  task automatic test_ports;
    acc_in <= 8'hA5;
    run({PAT_PORT_OUT, SEL_P1}, 0, 8'h00, 2);
    check(16'(port1_out), 16'h00A5);
    acc_in <= 8'h3C;
    run({PAT_PORT_OUT, SEL_P2}, 0, 8'h00, 2);
    check(16'(port2_out), 16'h003C);
    run({PAT_PORT_AND, SEL_P1}, 1, 8'h0F, 2);
    check(16'(port1_out), 16'h0005);
    run({PAT_PORT_OR, SEL_P2}, 1, 8'h40, 2);
    check(16'(port2_out), 16'h007C);
    run({PAT_PORT_IN, SEL_P1}, 0, 8'h00, 2);
    check({7'h00, got_we, got_acc}, 16'h0101);
    run({PAT_PORT_IN, SEL_P2}, 0, 8'h00, 2);
    check({7'h00, got_we, got_acc}, 16'h015C);
  endtask

  // every expander port: write, read back, then AND and OR with the low nibble
  task automatic test_expander;
    logic [3:0] v;
    for (int s = 0; s < 4; s++) begin
      v = 4'(s + 5);
      acc_in <= {4'hA, v};
      run({PAT_EXP_WR, 2'(s)}, 0, 8'h00, 2);
      check(16'(exp_nibs[s*4 +: 4]), 16'(v));
      check(16'(got_we), 16'h0);
      run({PAT_EXP_RD, 2'(s)}, 0, 8'h00, 2);
      check({7'h00, got_we, got_acc}, {8'h01, 4'h0, v});
      acc_in <= 8'hF6;
      run({PAT_EXP_AND, 2'(s)}, 0, 8'h00, 2);
      check(16'(exp_nibs[s*4 +: 4]), 16'(v & 4'h6));
      acc_in <= 8'h09;
      run({PAT_EXP_OR, 2'(s)}, 0, 8'h00, 2);
      check(16'(exp_nibs[s*4 +: 4]), 16'((v & 4'h6) | 4'h9));
    end
  endtask

  task automatic test_bus;
    run(OP_BUS_CAP, 0, 8'h00, 2);
    check({7'h00, got_we, got_acc}, 16'h019E);
    check(16'(rd_lows), 16'h1);
    // program memory is internal here, so the bus latch is allowed
    acc_in <= 8'hC3;
    run(OP_BUS_OUT, 0, 8'h00, 2);
    check(16'(wr_seen), 16'h00C3);
    check(16'(wr_lows), 16'h1);
    check({7'h00, bus_oe, bus_out}, 16'h01C3);
    run(OP_BUS_AND, 1, 8'h0F, 2);
    check({7'h00, bus_oe, bus_out}, 16'h0103);
    run(OP_BUS_OR, 1, 8'h50, 2);
    check({7'h00, bus_oe, bus_out}, 16'h0153);
  endtask

  // registers are internal: timing and no accumulator write are what shows
  task automatic test_regs;
    for (int r = 0; r < 8; r++) begin
      run({PAT_REG_INC, 3'(r)}, 0, 8'h00, 1);
      run({PAT_REG_DEC, 3'(r)}, 0, 8'h00, 1);
      check(16'(got_we), 16'h0);
    end
    run({PAT_IND_INC, 1'b0}, 0, 8'h00, 2);
    run({PAT_IND_INC, 1'b1}, 0, 8'h00, 2);
    run(8'h00, 0, 8'h00, 0);
  endtask

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      complete_run;
    end
  end

  // reset, then the scenarios
  initial begin
    resetn = 1'b0;
    op_valid = 1'b0;
    op_byte = 8'h00;
    acc_in = 8'h00;
    rd_byte = 8'h9E;
    p1_pull = 8'hF3;
    p2_pull = 8'h5F;
    repeat (4) @(posedge clock);
    #1;
    check({rd_n, wr_n, op_ready, bus_oe, user_flag_one, user_flag_zero}, 16'h0038);
    check({port1_out, port2_out}, 16'h0000);
    @(posedge clock);
    resetn <= 1'b1;
    test_flags;
    test_ports;
    test_expander;
    test_bus;
    test_regs;
    complete_run;
  end
endmodule
`default_nettype wire
